/* File: hw/vpic_map.svh */
// Register indices, field positions, reset values and vector constants of the
// vectored priority interrupt controller.
// Assumes inclusion by bare name from the package and the design files.
`ifndef VPIC_MAP_SVH
`define VPIC_MAP_SVH

// Register indices on the register port
`define VPIC_IDX_CTRL_ONE   6'h00
`define VPIC_IDX_CTRL_TWO   6'h01
`define VPIC_IDX_FLAG0      6'h02
`define VPIC_IDX_EN0        6'h07
`define VPIC_IDX_PRIO0      6'h0C
`define VPIC_IDX_PENDING    6'h1E
`define VPIC_IDX_STATUS     6'h1F
`define VPIC_IDX_CORE       6'h20
`define VPIC_NUM_FLAG_REGS  5
`define VPIC_NUM_PRIO_REGS  18

// Global control one fields
`define VPIC_C1_NEST_DIS    15
`define VPIC_C1_WMASK       16'hFFFE
// Trap status bits in global control one: osc, addr, stack, math, transfer
`define VPIC_C1_OSC         1
`define VPIC_C1_STK         2
`define VPIC_C1_ADDR        3
`define VPIC_C1_MATH        4
`define VPIC_C1_XFER        5

// Global control two fields
`define VPIC_C2_ALT         15
`define VPIC_C2_WMASK       16'h801F
`define VPIC_NUM_EXT        5

// Status word and core control fields
`define VPIC_SR_LVL_LO      5
`define VPIC_CORE_TOP       3

// Vectors and table addresses
`define VPIC_USER_VEC_BASE  7'h08
`define VPIC_IVT_BASE       24'h00_0004
`define VPIC_ALTERNATE_VECTOR_TABLE_OFFSET    24'h00_0100
`define VPIC_TRAP_TOP_LVL   4'hF

// Reset values
`define VPIC_RST_WORD       16'h0000
`define VPIC_RST_LEVEL      4'h0

`endif

/* File: hw/vpic_pkg.sv */
// Types shared by the interrupt controller files.
// Assumes vpic_map.svh is on the include path.
package vpic_pkg;
    `include "vpic_map.svh"

    // One register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } vpic_bus_t;

    // Vector number and new level as latched for the CPU
    typedef struct packed {
        logic [6:0] vec;
        logic [3:0] lvl;
    } vpic_pend_t;
endpackage : vpic_pkg

/* File: hw/vpic_arbiter.sv */
// Priority search over the user request lines.
// Assumes requests are already qualified by flag and enable; purely combinational.
module vpic_arbiter
    import vpic_pkg::*;
#(
    parameter int NSRC = 72
)
(
    // Qualified requests and their levels
    input  wire logic [NSRC-1:0]      req,
    input  wire logic [NSRC-1:0][2:0] prio,
    // Winner
    output logic                      found,
    output logic [6:0]                idx,
    output logic [2:0]                lvl
);
    // Walk from the top index down; ">=" lets the lower index win a tie
    always_comb
    begin
        found = 1'b0;
        idx   = 7'h00;
        lvl   = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (req[i] && (!found || prio[i] >= lvl))
            begin
                found = 1'b1;
                idx   = 7'(i);
                lvl   = prio[i];
            end
        end
    end
endmodule : vpic_arbiter

/* File: hw/vpic_ctrl.sv */
// Vectored priority interrupt controller: flag, enable and priority registers,
// trap status, CPU level and the latched pending vector.
// Assumes request and trap pulses come from logic on clk; external pins do not.
//
// Local design decisions: the plain strobed port and the register offsets.
module vpic_ctrl
    import vpic_pkg::*;
#(
    parameter int NSRC = 72
)
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Register port
    input  wire vpic_bus_t     bus,
    output logic [15:0]        rdata_r,
    // Request sources
    input  wire logic [NSRC-1:0] periph_req,
    input  wire logic [4:0]    ext_pin,
    input  wire logic [4:0]    trap_evt,
    // CPU side
    input  wire logic          irq_ack,
    output logic               irq_req_r,
    output logic [6:0]         irq_vector_r,
    output logic [3:0]         irq_level_r,
    output logic [23:0]        irq_addr_r,
    output logic [3:0]         cpu_level_r
);
    localparam int NBITS = `VPIC_NUM_FLAG_REGS * 16;

    // Request numbers of the five external pins
    localparam logic [4:0][6:0] EXT_SRC = {7'd54, 7'd53, 7'd29, 7'd20, 7'd0};
    // Trap vector numbers, in the order of the trap_evt bits
    localparam logic [4:0][2:0] TRAP_VEC = {3'd5, 3'd4, 3'd3, 3'd2, 3'd1};
    // Where each trap keeps its status bit in control one
    localparam logic [4:0][3:0] TRAP_BIT = {4'(`VPIC_C1_XFER), 4'(`VPIC_C1_MATH),
                                            4'(`VPIC_C1_STK), 4'(`VPIC_C1_ADDR),
                                            4'(`VPIC_C1_OSC)};

    // Register state
    logic [15:0]            ctrl_one_r, ctrl_one_nxt;
    logic [15:0]            ctrl_two_r, ctrl_two_nxt;
    logic [NBITS-1:0]       flag_r, flag_nxt;
    logic [NBITS-1:0]       en_r, en_nxt;
    logic [NSRC-1:0][2:0]   prio_r, prio_nxt;
    vpic_pend_t             pend_r, pend_nxt;
    logic [3:0]             lvl_nxt;
    logic [15:0]            rdata_nxt;
    logic                   irq_req_nxt;
    logic [6:0]             irq_vector_nxt;
    logic [3:0]             irq_level_nxt;
    logic [23:0]            irq_addr_nxt;

    // Pin synchronisers and edge detect
    logic [4:0]             pin_s1_r, pin_s2_r, pin_s3_r;
    logic [4:0]             pin_edge;
    logic [NBITS-1:0]       hw_set;

    // Arbitration
    logic [NSRC-1:0]        user_req;
    logic                   user_found;
    logic [6:0]             user_idx;
    logic [2:0]             user_lvl;
    logic                   user_ok;
    logic                   trap_found;
    logic [2:0]             trap_vec;

    // Write decode helpers
    logic [5:0]             idx_flag, idx_en, idx_prio;
    assign idx_flag = bus.addr - `VPIC_IDX_FLAG0;
    assign idx_en   = bus.addr - `VPIC_IDX_EN0;
    assign idx_prio = bus.addr - `VPIC_IDX_PRIO0;

    // Pins cross into clk through two flops; the third only feeds the edge detect
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_r <= 5'h0;
            pin_s2_r <= 5'h0;
            pin_s3_r <= 5'h0;
        end
        else
        begin
            pin_s1_r <= ext_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Polarity bit set selects the falling edge
    always_comb
    begin
        for (int p = 0; p < `VPIC_NUM_EXT; p++)
        begin
            pin_edge[p] = ctrl_two_r[p] ? (pin_s3_r[p] & ~pin_s2_r[p])
                                        : (~pin_s3_r[p] & pin_s2_r[p]);
        end
    end

    // Hardware set lines for every flag bit
    always_comb
    begin
        hw_set = '0;
        hw_set[NSRC-1:0] = periph_req;
        for (int p = 0; p < `VPIC_NUM_EXT; p++)
        begin
            hw_set[EXT_SRC[p]] = hw_set[EXT_SRC[p]] | pin_edge[p];
        end
    end

    // Register writes; a hardware set in the clearing cycle wins
    always_comb
    begin
        ctrl_one_nxt = ctrl_one_r;
        ctrl_two_nxt = ctrl_two_r;
        flag_nxt     = flag_r;
        en_nxt       = en_r;
        prio_nxt     = prio_r;
        if (bus.wr && bus.addr == `VPIC_IDX_CTRL_ONE)
        begin
            ctrl_one_nxt = bus.wdata & `VPIC_C1_WMASK;
        end
        if (bus.wr && bus.addr == `VPIC_IDX_CTRL_TWO)
        begin
            ctrl_two_nxt = bus.wdata & `VPIC_C2_WMASK;
        end
        for (int w = 0; w < `VPIC_NUM_FLAG_REGS; w++)
        begin
            if (bus.wr && idx_flag == 6'(w))
            begin
                flag_nxt[w*16 +: 16] = bus.wdata;
            end
            if (bus.wr && idx_en == 6'(w))
            begin
                en_nxt[w*16 +: 16] = bus.wdata;
            end
        end
        for (int s = 0; s < NSRC; s++)
        begin
            if (bus.wr && idx_prio == 6'(s / 4))
            begin
                prio_nxt[s] = bus.wdata[(s % 4)*4 +: 3];
            end
        end
        flag_nxt = flag_nxt | hw_set;
        for (int t = 0; t < 5; t++)
        begin
            if (trap_evt[t])
            begin
                ctrl_one_nxt[TRAP_BIT[t]] = 1'b1;
            end
        end
        // Bits above the last source do not exist
        for (int b = NSRC; b < NBITS; b++)
        begin
            flag_nxt[b] = 1'b0;
            en_nxt[b]   = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_one_r <= `VPIC_RST_WORD;
            ctrl_two_r <= `VPIC_RST_WORD;
            flag_r     <= '0;
            en_r       <= '0;
            prio_r     <= '0;
        end
        else
        begin
            ctrl_one_r <= ctrl_one_nxt;
            ctrl_two_r <= ctrl_two_nxt;
            flag_r     <= flag_nxt;
            en_r       <= en_nxt;
            prio_r     <= prio_nxt;
        end
    end

    // Only flagged and enabled sources compete
    assign user_req = flag_r[NSRC-1:0] & en_r[NSRC-1:0];

    vpic_arbiter #(
        .NSRC (NSRC)
    ) u_arb (
        .req   (user_req),
        .prio  (prio_r),
        .found (user_found),
        .idx   (user_idx),
        .lvl   (user_lvl)
    );

    // Strictly above the CPU level, and never while the top bit is set
    assign user_ok = user_found && !cpu_level_r[3]
                     && ({1'b0, user_lvl} > cpu_level_r);

    // Lowest trap vector wins; traps ignore the CPU level
    always_comb
    begin
        trap_found = 1'b0;
        trap_vec   = 3'h0;
        for (int t = 4; t >= 0; t--)
        begin
            if (ctrl_one_r[TRAP_BIT[t]])
            begin
                trap_found = 1'b1;
                trap_vec   = TRAP_VEC[t];
            end
        end
    end

    // Select the vector, its level and its table address
    always_comb
    begin
        pend_nxt       = pend_r;
        irq_req_nxt    = 1'b0;
        irq_vector_nxt = irq_vector_r;
        irq_level_nxt  = irq_level_r;
        irq_addr_nxt   = irq_addr_r;
        if (trap_found)
        begin
            pend_nxt.vec = {4'h0, trap_vec};
            pend_nxt.lvl = `VPIC_TRAP_TOP_LVL - {1'b0, trap_vec};
            irq_req_nxt  = 1'b1;
        end
        else if (user_ok)
        begin
            pend_nxt.vec = user_idx + `VPIC_USER_VEC_BASE;
            pend_nxt.lvl = {1'b0, user_lvl};
            irq_req_nxt  = 1'b1;
        end
        if (irq_req_nxt)
        begin
            irq_vector_nxt = pend_nxt.vec;
            irq_level_nxt  = pend_nxt.lvl;
            irq_addr_nxt   = `VPIC_IVT_BASE + {16'h0, pend_nxt.vec, 1'b0}
                             + (ctrl_two_r[`VPIC_C2_ALT] ? `VPIC_ALTERNATE_VECTOR_TABLE_OFFSET
                                                         : 24'h00_0000);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_r       <= '0;
            irq_req_r    <= 1'b0;
            irq_vector_r <= 7'h00;
            irq_level_r  <= `VPIC_RST_LEVEL;
            irq_addr_r   <= 24'h00_0000;
        end
        else
        begin
            pend_r       <= pend_nxt;
            irq_req_r    <= irq_req_nxt;
            irq_vector_r <= irq_vector_nxt;
            irq_level_r  <= irq_level_nxt;
            irq_addr_r   <= irq_addr_nxt;
        end
    end

    // CPU level: acknowledge loads the new level, which for a trap can be below the current one, and beats software
    always_comb
    begin
        lvl_nxt = cpu_level_r;
        if (bus.wr && bus.addr == `VPIC_IDX_STATUS
            && !ctrl_one_r[`VPIC_C1_NEST_DIS])
        begin
            lvl_nxt[2:0] = bus.wdata[`VPIC_SR_LVL_LO +: 3];
        end
        if (bus.wr && bus.addr == `VPIC_IDX_CORE && !bus.wdata[`VPIC_CORE_TOP])
        begin
            lvl_nxt[3] = 1'b0;
        end
        if (irq_ack && irq_req_r)
        begin
            lvl_nxt = irq_level_r;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_level_r <= `VPIC_RST_LEVEL;
        end
        else
        begin
            cpu_level_r <= lvl_nxt;
        end
    end

    // Read data stand only in the cycle after the read strobe
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (bus.rd)
        begin
            if (bus.addr == `VPIC_IDX_CTRL_ONE)
            begin
                rdata_nxt = ctrl_one_r;
            end
            else if (bus.addr == `VPIC_IDX_CTRL_TWO)
            begin
                rdata_nxt = ctrl_two_r;
            end
            else if (bus.addr == `VPIC_IDX_PENDING)
            begin
                rdata_nxt = {5'h0, pend_r.lvl, pend_r.vec};
            end
            else if (bus.addr == `VPIC_IDX_STATUS)
            begin
                rdata_nxt[`VPIC_SR_LVL_LO +: 3] = cpu_level_r[2:0];
            end
            else if (bus.addr == `VPIC_IDX_CORE)
            begin
                rdata_nxt[`VPIC_CORE_TOP] = cpu_level_r[3];
            end
            for (int w = 0; w < `VPIC_NUM_FLAG_REGS; w++)
            begin
                if (idx_flag == 6'(w))
                begin
                    rdata_nxt = flag_r[w*16 +: 16];
                end
                if (idx_en == 6'(w))
                begin
                    rdata_nxt = en_r[w*16 +: 16];
                end
            end
            for (int s = 0; s < NSRC; s++)
            begin
                if (idx_prio == 6'(s / 4))
                begin
                    rdata_nxt[(s % 4)*4 +: 3] = prio_r[s];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= 16'h0000;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end
endmodule : vpic_ctrl

/* File: sim/vpic_ctrl_monitor.sv */
// Checker for the interrupt controller outputs against their causes.
// Assumes a bind onto vpic_ctrl; one clock, reset asynchronous and high.
module vpic_ctrl_monitor
    import vpic_pkg::*;
#(
    parameter int NSRC = 72
)
(
    // Clock and reset
    input wire logic            clk,
    input wire logic            rst,
    // Register port
    input wire vpic_bus_t       bus,
    input wire logic [15:0]     rdata_r,
    // Request sources
    input wire logic [NSRC-1:0] periph_req,
    input wire logic [4:0]      ext_pin,
    input wire logic [4:0]      trap_evt,
    // CPU side
    input wire logic            irq_ack,
    input wire logic            irq_req_r,
    input wire logic [6:0]      irq_vector_r,
    input wire logic [3:0]      irq_level_r,
    input wire logic [23:0]     irq_addr_r,
    input wire logic [3:0]      cpu_level_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A trap pulse is flagged, then presented whatever the CPU level is
    sequence s_trap_taken;
        ##2 irq_req_r && irq_vector_r inside {[1:5]}
            && irq_level_r == 4'hF - irq_vector_r[3:0];
    endsequence

    // Read data only in the cycle after a read strobe
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata_r == 16'h0000)
        else $error("read data outside its cycle");
    a_ack_level: assert property (irq_ack |=> cpu_level_r == $past(irq_level_r))
        else $error("taken level not loaded");
    a_addr_vec: assert property (irq_req_r |-> irq_addr_r[7:0] == {irq_vector_r, 1'b0} + 8'h04
        && irq_addr_r[23:9] == 15'h0000)
        else $error("vector address wrong");
    // Request in a cycle reflects the level of the cycle before
    a_user_above: assert property (irq_req_r && irq_vector_r >= 7'h08 |-> irq_vector_r < 7'h50
        && $past(cpu_level_r) < {1'b0, irq_level_r[2:0]} && !irq_level_r[3])
        else $error("user request not above level");
    a_pend_hold: assert property (!irq_req_r |-> $stable(irq_vector_r) && $stable(irq_level_r))
        else $error("pending vector moved without winner");
    a_trap_taken: assert property (trap_evt != 5'h00 |-> s_trap_taken)
        else $error("trap not presented");
    a_level_cause: assert property ($changed(cpu_level_r) |-> $past(irq_ack) || $past(bus.wr))
        else $error("level changed without cause");
    a_top_bit_ro: assert property ($rose(cpu_level_r[3]) |-> $past(irq_ack))
        else $error("top level bit set by software");
endmodule : vpic_ctrl_monitor

bind vpic_ctrl vpic_ctrl_monitor #(.NSRC(NSRC)) u_mon (
    .clk          (clk),
    .rst          (rst),
    .bus          (bus),
    .rdata_r      (rdata_r),
    .periph_req   (periph_req),
    .ext_pin      (ext_pin),
    .trap_evt     (trap_evt),
    .irq_ack      (irq_ack),
    .irq_req_r    (irq_req_r),
    .irq_vector_r (irq_vector_r),
    .irq_level_r  (irq_level_r),
    .irq_addr_r   (irq_addr_r),
    .cpu_level_r  (cpu_level_r)
);

/* File: sim/vpic_cpu_model.sv */
// CPU stand-in: takes a presented interrupt by a one-cycle acknowledge.
// Assumes irq_req_r is registered on the same clock.
module vpic_cpu_model
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Bench control and controller request
    input  wire logic ack_on,
    input  wire logic irq_req_r,
    output logic      irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap_r;

    // The request drops two cycles after a take, so wait that out first
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_ack <= 1'b0;
            gap_r   <= 2'h0;
        end
        else
        begin
            irq_ack <= ack_on && irq_req_r && gap_r == 2'h0 && !irq_ack;
            gap_r   <= irq_ack ? 2'h3 : (gap_r != 2'h0 ? gap_r - 2'h1 : 2'h0);
        end
    end
endmodule : vpic_cpu_model

/* File: sim/vpic_ctrl_test.sv */
// Self-checking bench: register port tasks, request pulses, CPU stand-in.
// Assumes design, checker and CPU model are compiled ahead of it.
module vpic_ctrl_test import vpic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ack_on = 1'b0;
    logic        irq_ack;
    logic        irq_req_r;
    vpic_bus_t   bus = '0;
    logic [15:0] rdata_r;
    logic [71:0] periph_req = '0;
    logic [4:0]  ext_pin = 5'h00;
    logic [4:0]  trap_evt = 5'h00;
    logic [6:0]  irq_vector_r;
    logic [3:0]  irq_level_r;
    logic [3:0]  cpu_level_r;
    logic [23:0] irq_addr_r;
    int          n_errors = 0;
    int          checked = 0;

    always #10 clk = ~clk;

    vpic_ctrl #(.NSRC(72)) dut (
        .clk          (clk),
        .rst          (rst),
        .bus          (bus),
        .rdata_r      (rdata_r),
        .periph_req   (periph_req),
        .ext_pin      (ext_pin),
        .trap_evt     (trap_evt),
        .irq_ack      (irq_ack),
        .irq_req_r    (irq_req_r),
        .irq_vector_r (irq_vector_r),
        .irq_level_r  (irq_level_r),
        .irq_addr_r   (irq_addr_r),
        .cpu_level_r  (cpu_level_r)
    );

    vpic_cpu_model cpu (
        .clk       (clk),
        .rst       (rst),
        .ack_on    (ack_on),
        .irq_req_r (irq_req_r),
        .irq_ack   (irq_ack)
    );

    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk) bus <= {2'b10, a, d};
        @(posedge clk) bus <= '0;
    endtask : wr

    // Read data stand only one cycle, so sample right after the taking edge
    task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
        @(posedge clk) bus <= {2'b01, a, 16'h0000};
        @(posedge clk) bus <= '0;
        #1 chk(what, {8'h00, exp}, {8'h00, rdata_r});
    endtask : rd

    task automatic pulse(input int n);
        @(posedge clk) periph_req[n] <= 1'b1;
        @(posedge clk) periph_req[n] <= 1'b0;
        cyc(1);
    endtask : pulse

    // Run takes about 90 cycles; the 2500-cycle limit is over twenty times that, so reaching it is a hang
    initial
    begin
        #50us;
        n_errors++;
        finish_test();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk("reset level", 24'h00_0000, 24'(cpu_level_r));
        rd(6'h3F, 16'h0000, "unmapped");
        rd(6'h00, 16'h0000, "ctrl one");
        // Request 46 at level 3
        wr(6'h09, 16'h4000);
        wr(6'h17, 16'h0300);
        pulse(46);
        chk("vector", 24'h00_0036, 24'(irq_vector_r));
        chk("new level", 24'h00_0003, 24'(irq_level_r));
        chk("address", 24'h00_0070, irq_addr_r);
        rd(6'h04, 16'h4000, "flag word");
        rd(6'h1E, 16'h01B6, "pending");
        // Disabled source flags but never wins
        pulse(0);
        rd(6'h02, 16'h0001, "flag zero");
        chk("disabled", 24'h00_0036, 24'(irq_vector_r));
        // Equal priority: lower request wins
        wr(6'h07, 16'h0002);
        wr(6'h0C, 16'h0030);
        pulse(1);
        chk("tie", 24'h00_0009, 24'(irq_vector_r));
        wr(6'h01, 16'h8000);
        cyc(1);
        chk("alt address", 24'h00_0116, irq_addr_r);
        wr(6'h17, 16'h0500);
        cyc(1);
        chk("higher prio", 24'h00_0036, 24'(irq_vector_r));
        // Level 5 masks both
        wr(6'h1F, 16'h00A0);
        cyc(1);
        chk("masked", 24'h00_0000, 24'(irq_req_r));
        rd(6'h1F, 16'h00A0, "status");
        wr(6'h00, 16'h8000);
        wr(6'h1F, 16'h0000);
        rd(6'h1F, 16'h00A0, "frozen");
        wr(6'h00, 16'h0000);
        // Address trap is taken while users are masked
        ack_on <= 1'b1;
        @(posedge clk) trap_evt[1] <= 1'b1;
        @(posedge clk) trap_evt[1] <= 1'b0;
        cyc(3);
        ack_on <= 1'b0;
        chk("trap vector", 24'h00_0002, 24'(irq_vector_r));
        chk("trap address", 24'h00_0108, irq_addr_r);
        chk("trap level", 24'h00_000D, 24'(cpu_level_r));
        rd(6'h00, 16'h0008, "trap flag");
        rd(6'h20, 16'h0008, "top bit");
        wr(6'h00, 16'h0000);
        cyc(1);
        chk("top blocks", 24'h00_0000, 24'(irq_req_r));
        wr(6'h20, 16'h0000);
        cyc(1);
        chk("top cleared", 24'h00_0005, 24'(cpu_level_r));
        // Pin 1 feeds request 20 at level 7; rising edge is the default
        wr(6'h11, 16'h0007);
        wr(6'h08, 16'h0010);
        @(posedge clk) ext_pin[1] <= 1'b1;
        cyc(5);
        chk("pin vector", 24'h00_001C, 24'(irq_vector_r));
        chk("pin address", 24'h00_013C, irq_addr_r);
        // Falling polarity: a high pin sets nothing until it drops
        wr(6'h01, 16'h8002);
        wr(6'h03, 16'h0000);
        rd(6'h03, 16'h0000, "pin flag clear");
        @(posedge clk) ext_pin[1] <= 1'b0;
        cyc(5);
        rd(6'h03, 16'h0010, "pin fall");
        finish_test();
    end
endmodule : vpic_ctrl_test
